// >>> design/qda_port.sv
// Summary of operation
// [RL1] autostep on: each data read advances receive pointer by 1, 2 or 4
// [RL2] autostep off: receive pointer changes only on host pointer writes; the code also reloads it on frame release
// [RL3] receive pointer is 11-bit, host-writable, resets to zero, selects byte
// [RL4] frame release reloads receive pointer with next frame location
// [RL5] low data register reads receive queue, writes go to transmit queue
// [RL6] high data register does the same for the upper word
// [RL7] any pointer alignment works without host realignment
// [RL8] byte, word, dword accesses mix freely, pointers stay consistent
// [RL9] low and high data form one word slot on the 32-bit bus
// [RL10] one one-way path each way: writes to transmit, reads from receive
// [RL11] release bit clears itself when memory is freed; host waits for it
// [RL12] transmit autostep on: data writes advance transmit pointer by size
// [RL13] pointer increments wrap modulo 11 bits
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module qda_port (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // receive queue fill from frame side
  input  wire logic        rxq_wr_en,
  input  wire logic [10:0] rxq_wr_addr,
  input  wire logic [7:0]  rxq_wr_data,
  // frame release handshake with queue manager
  output logic             rel_req,
  input  wire logic        rel_done,
  input  wire logic [10:0] rx_next_frame,
  // transmit queue write stream
  output logic             txq_valid,
  input  wire logic        txq_ready,
  output logic [10:0]      txq_addr,
  output logic [1:0]       txq_size,
  output logic [31:0]      txq_data
);
  import qda_pkg::*;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [10:0] size_step(input logic [1:0] sz);
    unique case (sz)
      SZ_BYTE: size_step = 11'h001;
      SZ_WORD: size_step = 11'h002;
      default: size_step = 11'h004;
    endcase
  endfunction

  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    unique case (sz)
      SZ_BYTE: size_mask = 32'h0000_00ff;
      SZ_WORD: size_mask = 32'h0000_ffff;
      default: size_mask = 32'hffff_ffff;
    endcase
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  logic [7:0]  rxq_mem [RXQ_BYTES];
  logic [10:0] rx_ptr_q;
  logic        rx_auto_q;
  logic [10:0] tx_ptr_q;
  logic        tx_auto_q;
  logic [1:0]  acc_size_q;
  qda_rel_t    rel_q;
  logic [31:0] prdata_q;
  logic        rd_ready_q;

  // -------------------------------------------------------------
  // decode
  // -------------------------------------------------------------
  logic        sel_rel;
  logic        sel_txp;
  logic        sel_rxp;
  logic        sel_lo;
  logic        sel_hi;
  logic        sel_sz;
  logic        sel_data;
  logic        mapped;
  logic        access;
  logic        done;
  logic        wr_done;
  logic        rd_done;
  logic        fifo_in_ready;
  logic [10:0] base;
  logic [10:0] step;
  logic [31:0] rd_gather;
  logic [31:0] rd_value;
  logic        rel_set;
  logic        rel_clear;

  assign sel_rel  = (paddr == ADDR_REL_CMD);
  assign sel_txp  = (paddr == ADDR_TX_PTR);
  assign sel_rxp  = (paddr == ADDR_RX_PTR);
  assign sel_lo   = (paddr == ADDR_DATA_LO);
  assign sel_hi   = (paddr == ADDR_DATA_HI);
  assign sel_sz   = (paddr == ADDR_ACC_SIZE);
  assign sel_data = sel_lo || sel_hi;
  assign mapped   = sel_rel || sel_txp || sel_rxp || sel_data || sel_sz;
  assign access   = psel && penable;
  assign step     = size_step(acc_size_q);

  // high register starts two bytes past the pointer, one word slot in all
  assign base = sel_hi ? rx_ptr_q + HI_OFFSET : rx_ptr_q;  // [RL6] [RL9]

  // byte gather wraps inside the buffer, so odd pointers need no realign
  always_comb begin
    rd_gather = {rxq_mem[base + 11'h003], rxq_mem[base + 11'h002],
                 rxq_mem[base + 11'h001], rxq_mem[base]};  // [RL7] [RL13]
  end

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (1'b1)
      sel_rel: rd_value[REL_BIT] = (rel_q == REL_BUSY);
      sel_txp: rd_value = {17'h0, tx_auto_q, 3'h0, tx_ptr_q};
      sel_rxp: rd_value = {17'h0, rx_auto_q, 3'h0, rx_ptr_q};  // [RL3]
      sel_data: rd_value = rd_gather & size_mask(acc_size_q);  // [RL5] [RL6]
      sel_sz: rd_value = {30'h0, acc_size_q};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // writes to data registers stall while the transmit buffer is full
  always_comb begin
    if (!access) begin
      pready = 1'b0;
    end else if (pwrite) begin
      pready = (sel_data && mapped) ? fifo_in_ready : 1'b1;
    end else begin
      pready = rd_ready_q;
    end
  end

  assign pslverr = access && pready && !mapped;
  assign prdata  = prdata_q;
  assign done    = access && pready;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;

  // -------------------------------------------------------------
  // read data: one wait state, data out of a flop
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q   <= 32'h0000_0000;
      rd_ready_q <= 1'b0;
    end else begin
      if (access && !pwrite && !rd_ready_q) begin
        prdata_q   <= rd_value;
        rd_ready_q <= 1'b1;
      end else begin
        rd_ready_q <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // receive queue memory, filled by the frame side
  // -------------------------------------------------------------
  always_ff @(posedge pclk) begin
    if (rxq_wr_en) begin
      rxq_mem[rxq_wr_addr] <= rxq_wr_data;
    end
  end

  // -------------------------------------------------------------
  // receive pointer
  // -------------------------------------------------------------
  // release reload beats a concurrent host access: the old frame is gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ptr_q  <= PTR_RST;  // [RL3]
      rx_auto_q <= AUTOSTEP_RST;
    end else begin
      if (rel_q == REL_BUSY && rel_done) begin
        rx_ptr_q <= rx_next_frame;  // [RL4]
      end else if (wr_done && sel_rxp) begin
        rx_ptr_q <= pwdata[PTR_W-1:0];  // [RL2] [RL3]
      end else if (rd_done && sel_data && rx_auto_q) begin
        rx_ptr_q <= rx_ptr_q + step;  // [RL1] [RL8] [RL13]
      end
      if (wr_done && sel_rxp) begin
        rx_auto_q <= pwdata[AUTOSTEP_BIT];
      end
    end
  end

  // -------------------------------------------------------------
  // transmit pointer and access size
  // -------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ptr_q  <= PTR_RST;
      tx_auto_q <= AUTOSTEP_RST;
    end else begin
      if (wr_done && sel_txp) begin
        tx_ptr_q  <= pwdata[PTR_W-1:0];
        tx_auto_q <= pwdata[AUTOSTEP_BIT];
      end else if (wr_done && sel_data && tx_auto_q) begin
        tx_ptr_q <= tx_ptr_q + step;  // [RL12] [RL13]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_size_q <= SZ_RST;
    end else if (wr_done && sel_sz) begin
      acc_size_q <= pwdata[1:0];  // [RL8]
    end
  end

  // -------------------------------------------------------------
  // frame release: set by host, cleared when memory is freed
  // -------------------------------------------------------------
  assign rel_set   = wr_done && sel_rel && pwdata[REL_BIT];
  assign rel_clear = (rel_q == REL_BUSY) && rel_done;
  assign rel_req   = (rel_q == REL_BUSY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rel_q <= REL_IDLE;
    end else begin
      unique case (rel_q)
        REL_IDLE: begin
          if (rel_set) begin
            rel_q <= REL_BUSY;
          end
        end
        REL_BUSY: begin
          if (rel_clear && !rel_set) begin
            rel_q <= REL_IDLE;  // [RL11]
          end
        end
        default: rel_q <= REL_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // transmit path buffer
  // -------------------------------------------------------------
  logic [TXF_WIDTH-1:0] fifo_out;
  logic [10:0]          tx_base;

  assign tx_base = sel_hi ? tx_ptr_q + HI_OFFSET : tx_ptr_q;  // [RL6] [RL9]

  qda_fifo #(
    .WIDTH (TXF_WIDTH),
    .DEPTH (TXF_DEPTH)
  ) u_txf (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (access && pwrite && sel_data),  // [RL5] [RL10]
    .in_ready  (fifo_in_ready),
    .in_data   ({tx_base, acc_size_q, pwdata & size_mask(acc_size_q)}),
    .out_valid (txq_valid),
    .out_ready (txq_ready),
    .out_data  (fifo_out)
  );

  assign txq_addr = fifo_out[TXF_WIDTH-1 -: 11];
  assign txq_size = fifo_out[33:32];
  assign txq_data = fifo_out[31:0];

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rx_auto_step: assert property ( // [RL1]
    (rd_done && sel_data && rx_auto_q && !rel_clear)
      |=> rx_ptr_q == $past(rx_ptr_q) + $past(step))
    else $error("receive pointer did not step by access size");

  a_rx_ptr_hold: assert property ( // [RL2]
    (!rx_auto_q && !(wr_done && sel_rxp) && !rel_clear) |=> $stable(rx_ptr_q))
    else $error("receive pointer moved without a write");

  a_rx_ptr_write: assert property ( // [RL3]
    (wr_done && sel_rxp && !rel_clear) |=> rx_ptr_q == $past(pwdata[10:0]))
    else $error("receive pointer write lost");

  a_rel_reload: assert property ( // [RL4]
    rel_clear |=> rx_ptr_q == $past(rx_next_frame))
    else $error("release did not reload receive pointer");

  a_rd_data_path: assert property ( // [RL5]
    (access && !pwrite && !rd_ready_q && sel_data) ##1 rd_done
      |-> prdata == ($past(rd_gather) & size_mask(acc_size_q)))
    else $error("data read does not match receive queue bytes");

  a_tx_enqueue: assert property ( // [RL10]
    (wr_done && sel_data) |=> txq_valid)
    else $error("data write did not reach transmit buffer");

  a_rel_selfclear: assert property ( // [RL11]
    (rel_clear && !rel_set) |=> !rel_req)
    else $error("release bit did not clear");

  a_rel_request: assert property ( // [RL11]
    rel_set |=> rel_req)
    else $error("release request not raised");

  // an empty buffer, or one whose last entry drains in that cycle, puts the new entry at the head, where it is visible
  a_tx_entry: assert property ( // [RL5]
    (wr_done && sel_data && !txq_valid)
      |=> txq_addr == $past(tx_base) && txq_size == $past(acc_size_q)
        && txq_data == $past(pwdata & size_mask(acc_size_q)))
    else $error("transmit entry differs from the write");

  a_tx_auto_step: assert property ( // [RL12]
    (wr_done && sel_data && tx_auto_q)
      |=> tx_ptr_q == $past(tx_ptr_q) + $past(step))
    else $error("transmit pointer did not step");

  a_ptr_wrap: assert property ( // [RL13]
    (rd_done && sel_data && rx_auto_q && !rel_clear && rx_ptr_q == 11'h7ff
      && acc_size_q == SZ_WORD) |=> rx_ptr_q == 11'h001)
    else $error("receive pointer did not wrap");

  a_read_wait: assert property ( // local design decision: APB read answer after one wait state
    (access && !pwrite && !rd_ready_q) |=> (rd_ready_q && pready) [*1])
    else $error("read answer not one wait state");

  c_rx_dword_read: cover property (rd_done && sel_lo && acc_size_q == SZ_DWORD);
  c_tx_stall:      cover property (access && pwrite && sel_data && !fifo_in_ready);
  c_release:       cover property (rel_set ##[1:20] rel_clear);
  c_odd_byte:      cover property (rd_done && sel_data && rx_ptr_q[0]);
  c_hi_write:      cover property (wr_done && sel_hi);
endmodule // qda_port
`default_nettype wire

// >>> inc/qda_pkg.sv
`default_nettype none
package qda_pkg;
  // -------------------------------------------------------------
  // register map: printed offsets are word indices
  // -------------------------------------------------------------
  localparam logic [7:0] IDX_REL_CMD  = 8'h02;
  localparam logic [7:0] IDX_TX_PTR   = 8'h04;
  localparam logic [7:0] IDX_RX_PTR   = 8'h06;
  localparam logic [7:0] IDX_DATA_LO  = 8'h08;
  localparam logic [7:0] IDX_DATA_HI  = 8'h0a;
  localparam logic [7:0] IDX_ACC_SIZE = 8'h10;
  localparam logic [7:0] ADDR_REL_CMD  = 8'(IDX_REL_CMD * 4);
  localparam logic [7:0] ADDR_TX_PTR   = 8'(IDX_TX_PTR * 4);
  localparam logic [7:0] ADDR_RX_PTR   = 8'(IDX_RX_PTR * 4);
  localparam logic [7:0] ADDR_DATA_LO  = 8'(IDX_DATA_LO * 4);
  localparam logic [7:0] ADDR_DATA_HI  = 8'(IDX_DATA_HI * 4);
  localparam logic [7:0] ADDR_ACC_SIZE = 8'(IDX_ACC_SIZE * 4);
  // -------------------------------------------------------------
  // fields and reset values
  // -------------------------------------------------------------
  localparam int          AUTOSTEP_BIT = 14;
  localparam int          PTR_W        = 11;
  localparam int          REL_BIT      = 0;
  localparam logic [10:0] PTR_RST      = 11'h000;
  localparam logic        AUTOSTEP_RST = 1'b0;
  localparam logic [10:0] HI_OFFSET    = 11'h002;
  localparam int          RXQ_BYTES    = 2048;
  // -------------------------------------------------------------
  // access sizes
  // -------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_RST   = SZ_DWORD;
  // -------------------------------------------------------------
  // transmit path buffer
  // -------------------------------------------------------------
  localparam int TXF_DEPTH = 8;
  localparam int TXF_WIDTH = 11 + 2 + 32;
  typedef enum logic [1:0] {
    REL_IDLE = 2'b01,
    REL_BUSY = 2'b10
  } qda_rel_t;
endpackage
`default_nettype wire

// >>> design/qda_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module qda_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // qda_fifo
`default_nettype wire

// >>> verification/qda_qmgr_model.sv
`timescale 1ns/1ps
`default_nettype none
module qda_qmgr_model #(
  parameter int          REL_LAT    = 8,
  parameter logic [10:0] NEXT_FRAME = 11'h123
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // receive memory fill
  output logic             rxq_wr_en,
  output logic [10:0]      rxq_wr_addr,
  output logic [7:0]       rxq_wr_data,
  // release handshake
  input  wire logic        rel_req,
  output logic             rel_done,
  output logic [10:0]      rx_next_frame,
  // transmit sink
  input  wire logic        txq_valid,
  output logic             txq_ready,
  input  wire logic [10:0] txq_addr,
  input  wire logic [1:0]  txq_size,
  input  wire logic [31:0] txq_data
);
  logic        stall = 1'b0;
  logic        fill_done = 1'b0;
  logic [44:0] got[$];
  int          wait_n = 0;

  // -------------------------------------------------------------
  // receive memory fill, byte a holds a ^ 5a
  // -------------------------------------------------------------
  initial begin
    rxq_wr_en = 1'b0;
    rxq_wr_addr = 11'h000;
    rxq_wr_data = 8'h00;
    @(posedge presetn);
    for (int a = 0; a < 2048; a++) begin
      @(posedge pclk);
      rxq_wr_en   <= 1'b1;
      rxq_wr_addr <= 11'(a);
      rxq_wr_data <= 8'(a) ^ 8'h5a;
    end
    @(posedge pclk);
    rxq_wr_en <= 1'b0;
    fill_done <= 1'b1;
  end

  // -------------------------------------------------------------
  // release: slow answer, frame location only valid with the pulse
  // -------------------------------------------------------------
  initial rel_done = 1'b0;
  initial rx_next_frame = ~NEXT_FRAME;
  always @(posedge pclk) begin
    rel_done <= 1'b0;
    rx_next_frame <= ~NEXT_FRAME;
    if (rel_req === 1'b1 && rel_done !== 1'b1) begin
      wait_n <= wait_n + 1;
      if (wait_n == REL_LAT) begin
        rel_done <= 1'b1;
        rx_next_frame <= NEXT_FRAME;
        wait_n <= 0;
      end
    end
  end

  // -------------------------------------------------------------
  // transmit sink, stalls on demand
  // -------------------------------------------------------------
  initial txq_ready = 1'b0;
  always @(posedge pclk) begin
    txq_ready <= !stall;
    if (txq_valid === 1'b1 && txq_ready === 1'b1) begin
      got.push_back({txq_addr, txq_size, txq_data});
    end
  end
endmodule // qda_qmgr_model
`default_nettype wire

// >>> verification/qda_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module qda_port_tb;
  import qda_pkg::*;
  localparam logic [10:0] REL_NEXT = 11'h123;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, txq_data;
  logic        rxq_wr_en, rel_req, rel_done, txq_valid, txq_ready;
  logic [10:0] rxq_wr_addr, rx_next_frame, txq_addr;
  logic [7:0]  rxq_wr_data;
  logic [1:0]  txq_size;
  int          bad_count, cmp_count;

  qda_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rxq_wr_en(rxq_wr_en), .rxq_wr_addr(rxq_wr_addr),
    .rxq_wr_data(rxq_wr_data), .rel_req(rel_req), .rel_done(rel_done),
    .rx_next_frame(rx_next_frame), .txq_valid(txq_valid), .txq_ready(txq_ready),
    .txq_addr(txq_addr), .txq_size(txq_size), .txq_data(txq_data));
  qda_qmgr_model #(.NEXT_FRAME(REL_NEXT)) model (.pclk(pclk), .presetn(presetn),
    .rxq_wr_en(rxq_wr_en), .rxq_wr_addr(rxq_wr_addr), .rxq_wr_data(rxq_wr_data),
    .rel_req(rel_req), .rel_done(rel_done), .rx_next_frame(rx_next_frame),
    .txq_valid(txq_valid), .txq_ready(txq_ready), .txq_addr(txq_addr),
    .txq_size(txq_size), .txq_data(txq_data));

  always #20 pclk = ~pclk;

  // -------------------------------------------------------------
  // bus and compare helpers
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e, output int n);
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, a, d, r, e, n);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b0, a, 32'h0, r, e, n);
    chk(nm, r, x);
  endtask

  function automatic logic [31:0] rx_exp(input logic [10:0] b, input int nb);
    logic [31:0] v;
    v = '0;
    for (int k = 0; k < nb; k++) v[8*k +: 8] = 8'(b + 11'(k)) ^ 8'h5a;
    return v;
  endfunction

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_reset;
    rdc("rx ptr reset", ADDR_RX_PTR, 32'h0);
    rdc("tx ptr reset", ADDR_TX_PTR, 32'h0);
    rdc("release idle", ADDR_REL_CMD, 32'h0);
  endtask

  task automatic t_unmapped;
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b0, 8'h04, 32'h0, r, e, n);
    chk("unmapped err", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
  endtask

  task automatic t_rx_step;
    int          nb[4] = '{1, 2, 4, 4};
    logic [10:0] p;
    p = 11'h7fe;
    wr(ADDR_RX_PTR, 32'h4000 | 32'(p));
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_ACC_SIZE, 32'(i));
      rdc("rx data", ADDR_DATA_LO, rx_exp(p, nb[i]));
      p = p + 11'(nb[i]);
    end
    rdc("rx ptr step", ADDR_RX_PTR, 32'h4000 | 32'(p));
  endtask

  task automatic t_rx_hold;
    wr(ADDR_RX_PTR, 32'h3);
    wr(ADDR_ACC_SIZE, 32'(SZ_DWORD));
    rdc("rx high", ADDR_DATA_HI, rx_exp(11'h5, 4));
    rdc("rx low", ADDR_DATA_LO, rx_exp(11'h3, 4));
    rdc("rx low again", ADDR_DATA_LO, rx_exp(11'h3, 4));
    rdc("rx ptr held", ADDR_RX_PTR, 32'h3);
  endtask

  task automatic t_release;
    logic [31:0] r;
    logic        e;
    int          n;
    int          k;
    wr(ADDR_RX_PTR, 32'h4010);
    wr(ADDR_REL_CMD, 32'h1);
    chk("release request", 32'(rel_req), 32'h1);
    rdc("release pending", ADDR_REL_CMD, 32'h1);
    k = 0;
    do begin
      apb(1'b0, ADDR_REL_CMD, 32'h0, r, e, n);
      k++;
    end while (r[0] !== 1'b0 && k < 40);
    chk("release cleared", r, 32'h0);
    chk("release request low", 32'(rel_req), 32'h0);
    apb(1'b0, ADDR_RX_PTR, 32'h0, r, e, n);
    chk("reload ptr", r & 32'h7ff, 32'(REL_NEXT));
    rdc("frame data", ADDR_DATA_LO, rx_exp(REL_NEXT, 4));
  endtask

  // mixed sizes into a stalled sink: fills the buffer, ninth write waits
  task automatic t_tx;
    logic [1:0]  sz[9] = '{0, 0, 1, 1, 2, 2, 2, 2, 2};
    logic        hi[9] = '{0, 0, 0, 1, 0, 1, 0, 0, 0};
    logic [44:0] ex[9];
    logic [31:0] r, d;
    logic        e;
    int          n, nb, k;
    logic [10:0] p;
    p = 11'h7fe;
    model.stall <= 1'b1;
    wr(ADDR_TX_PTR, 32'h4000 | 32'(p));
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_ACC_SIZE, 32'(sz[i]));
      nb = (sz[i] == 2'h0) ? 1 : (sz[i] == 2'h1) ? 2 : 4;
      d = 32'hc3a5_9610 + 32'(i);
      if (i == 8) begin
        chk("full valid", 32'(txq_valid), 32'h1);
        fork
          begin
            repeat (10) @(posedge pclk);
            model.stall <= 1'b0;
          end
        join_none
      end
      apb(1'b1, hi[i] ? ADDR_DATA_HI : ADDR_DATA_LO, d, r, e, n);
      if (i == 8) chk("stalled write", 32'(n > 10), 32'h1);
      if (nb < 4) d = d & ((32'h1 << (8 * nb)) - 32'h1);
      ex[i] = {p + (hi[i] ? 11'h2 : 11'h0), sz[i], d};
      p = p + 11'(nb);
    end
    k = 0;
    while (model.got.size() < 9 && k < 50) begin
      @(posedge pclk);
      k++;
    end
    chk("tx count", 32'(model.got.size()), 32'd9);
    for (int i = 0; i < 9 && i < model.got.size(); i++) begin
      chk("tx addr size", 32'(model.got[i][44:32]), 32'(ex[i][44:32]));
      chk("tx data", model.got[i][31:0], ex[i][31:0]);
    end
    rdc("tx ptr step", ADDR_TX_PTR, 32'h4000 | 32'(p));
  endtask

  // -------------------------------------------------------------
  // run control
  // -------------------------------------------------------------
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_unmapped;
    while (model.fill_done !== 1'b1) @(posedge pclk);
    t_rx_step;
    t_rx_hold;
    t_release;
    t_tx;
    end_sim;
  end

  // hang guard, well beyond fill plus all scenarios
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    end_sim;
  end
endmodule // qda_port_tb
`default_nettype wire
